// ===== tuner_ctrl_defines.vh
// Shared constants of the tuner control register bank: sub-addresses,
// field positions, reset values and serial-frame figures.
// Assumes inclusion by bare name from the design files of this folder.
`ifndef TUNER_CTRL_DEFINES_VH
`define TUNER_CTRL_DEFINES_VH

// ----------------------------------------------------------------------
// Sub-addresses of the write-only configuration bytes
// ----------------------------------------------------------------------
`define SUB_FILTER_TRIM    3'h0
`define SUB_CHARGE_PUMP    3'h1
`define SUB_OSC_BAND       3'h2
`define SUB_OPERATING      3'h3
`define SUB_REF_DIV_POWER  3'h4
`define SUB_REF_DIVIDER    3'h5
`define SUB_FB_DIV_HIGH    3'h6
`define SUB_FB_DIV_LOW     3'h7
`define NUM_CFG_REGS       8

// ----------------------------------------------------------------------
// Reset values of the configuration bytes
// ----------------------------------------------------------------------
`define RST_FILTER_TRIM    8'h10
`define RST_CHARGE_PUMP    8'hF1
`define RST_OTHER          8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define TRIM_CODE_MSB      7
`define TRIM_CODE_LSB      5
`define TRIM_SRC_BIT       4
`define MIXER_DIS_BIT      3
`define DIAG_MSB           2
`define DIAG_LSB           0
`define PUMP_CUR_MSB       7
`define PUMP_CUR_LSB       6
`define PUMP_AUTO_BIT      5
`define PREBIAS_EN_BIT     4
`define REF_PREBIAS_BIT    3
`define FB_PREBIAS_BIT     2
`define PUMP_ON_BIT        1
`define AUTOSEL_EN_BIT     0
`define OSC_SEL_MSB        7
`define OSC_SEL_LSB        6
`define SUB_BAND_MSB       5
`define SUB_BAND_LSB       3
`define CONV_LATCH_BIT     2
`define CONV_EN_BIT        1
`define LOCK_TC_BIT        0
`define OUT_MODE_BIT       7
`define BB_LEVEL_MSB       6
`define BB_LEVEL_LSB       5
`define INJ_SIDE_BIT       4
`define DET_SET_MSB        3
`define DET_SET_LSB        1
`define DET_EN_BIT         0
`define REF_OUT_DIV_MSB    7
`define REF_OUT_DIV_LSB    3
`define PWR_DOWN_BIT       2
`define STANDBY_BIT        1
`define QUAD_OFF_BIT       0
`define FB_LOW_MSB         7
`define FB_LOW_LSB         3

// ----------------------------------------------------------------------
// Diagnostic select codes: normal (test output low), or a signal routed to the test output
// ----------------------------------------------------------------------
`define DIAG_NORMAL        3'h0
`define DIAG_FB_DIV        3'h5
`define DIAG_REF_DIV       3'h6
`define DIAG_LO            3'h7

// ----------------------------------------------------------------------
// Serial frame
// ----------------------------------------------------------------------
`define BITS_PER_BYTE      4'h8
`define DEV_ADDR_DEFAULT   7'h60

`endif

// ===== serial_line_frontend.v
// Two-wire line front end: synchronises clock and data lines into the
// system clock and reports clock edges and start and stop conditions.
// Assumes the serial clock is much slower than the system clock.
`timescale 1ns/10ps

module serial_line_frontend (
   input  wire mclk_i,        // System clock
   input  wire rst_i,         // Synchronous reset, active high
   input  wire scl_i,         // Serial clock pin level
   input  wire sda_i,         // Serial data pin level
   output wire sda_level_o,   // Synchronised data level
   output wire scl_rise_o,    // One-cycle pulse on clock rise
   output wire scl_fall_o,    // One-cycle pulse on clock fall
   output wire start_o,       // One-cycle pulse on start condition
   output wire stop_o         // One-cycle pulse on stop condition
);

   reg scl_meta;
   reg scl_sync;
   reg scl_dly;
   reg sda_meta;
   reg sda_sync;
   reg sda_dly;

   // -------------------------------------------------------------------
   // Two-stage synchronisers and one delay stage for edge detection
   // -------------------------------------------------------------------
   always @(posedge mclk_i) begin
      if (rst_i) begin
         scl_meta <= 1'b1;
         scl_sync <= 1'b1;
         scl_dly  <= 1'b1;
         sda_meta <= 1'b1;
         sda_sync <= 1'b1;
         sda_dly  <= 1'b1;
      end else begin
         scl_meta <= scl_i;
         scl_sync <= scl_meta;
         scl_dly  <= scl_sync;
         sda_meta <= sda_i;
         sda_sync <= sda_meta;
         sda_dly  <= sda_sync;
      end
   end

   assign sda_level_o = sda_sync;
   assign scl_rise_o  = scl_sync & ~scl_dly;
   assign scl_fall_o  = ~scl_sync & scl_dly;
   // Data moving while the clock stays high marks frame boundaries
   assign start_o     = scl_sync & scl_dly & sda_dly & ~sda_sync;
   assign stop_o      = scl_sync & scl_dly & ~sda_dly & sda_sync;

endmodule // serial_line_frontend

// ===== tuner_control_register_bank.v
// Control register bank of the tuner: eight write-only configuration
// bytes and two read-only status bytes behind a two-wire serial slave.
// Assumes status inputs and divider taps are synchronous to mclk_i and
// that the pad supplies the pull-up of the reference-select pin.
`timescale 1ns/10ps
`include "tuner_ctrl_defines.vh"

module tuner_control_register_bank #(
   parameter [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT   // Slave address on the link
) (
   input  wire        mclk_i,                 // System clock, 10 MHz
   input  wire        nrst_i,                 // Synchronous reset, active low
   input  wire        shutdown_pin_n_i,       // Shutdown pin, active low
   input  wire        scl_i,                  // Serial clock pin
   input  wire        sda_i,                  // Serial data pin level
   output wire        sda_o,                  // Serial data drive value
   output wire        sda_oe_o,               // Serial data drive enable
   input  wire        ref_source_select_i,    // Reference select pin
   input  wire [1:0]  act_pump_current_i,     // Active pump current code
   input  wire        power_indication_i,     // Power indication
   input  wire        autoselect_flag_a_i,    // Autoselect flag a
   input  wire        autoselect_flag_e_i,    // Autoselect flag e
   input  wire [1:0]  act_osc_select_i,       // Selected oscillator
   input  wire [2:0]  act_sub_band_i,         // Selected sub-band
   input  wire [2:0]  converter_reading_i,    // Converter reading
   input  wire        fb_div_tap_i,           // Feedback divider output
   input  wire        ref_div_tap_i,          // Reference divider output
   input  wire        lo_tap_i,               // Local oscillator tap
   output reg         test_out_o,             // Test output pin
   output wire        device_on_o,            // Device powered and active
   output wire        tcxo_enable_o,          // External oscillator enable
   output wire        xtal_enable_o,          // Crystal input enable
   output wire [2:0]  filter_trim_code_o,     // Filter trim code
   output wire        trim_source_select_o,   // Trim source select
   output wire        mixer_disable_o,        // Mixer disable
   output wire [2:0]  diag_select_o,          // Diagnostic select
   output wire [1:0]  pump_current_code_o,    // Pump current code
   output wire        pump_current_auto_o,    // Pump current auto mode
   output wire        prebias_enable_o,       // Prebias enable
   output wire        ref_prebias_time_o,     // Reference prebias time
   output wire        fb_prebias_time_o,      // Feedback prebias time
   output wire        pump_on_time_o,         // Pump on-time
   output wire        osc_autoselect_enable_o,// Oscillator autoselect enable
   output wire [1:0]  oscillator_select_o,    // Oscillator select
   output wire [2:0]  sub_band_select_o,      // Sub-band select
   output wire        converter_latch_o,      // Converter latch
   output wire        converter_enable_o,     // Converter enable
   output wire        lock_time_constant_o,   // Lock time constant
   output wire        output_mode_o,          // Output mode
   output wire [1:0]  baseband_level_o,       // Baseband level
   output wire        injection_side_o,       // Injection side
   output wire [2:0]  detector_setting_o,     // Power detector setting
   output wire        detector_enable_o,      // Power detector enable
   output wire [4:0]  ref_out_divide_o,       // Reference output divide
   output wire        power_down_o,           // Power-down in effect
   output wire        standby_o,              // Standby in effect
   output wire        quadrature_off_o,       // Quadrature output off
   output wire [7:0]  ref_divider_ratio_o,    // Reference divider ratio
   output wire [12:0] fb_divider_ratio_o      // Feedback divider ratio
);

   // -------------------------------------------------------------------
   // Link states
   // -------------------------------------------------------------------
   localparam [2:0] S_IDLE = 3'h0;
   localparam [2:0] S_ADDR = 3'h1;
   localparam [2:0] S_ACK  = 3'h2;
   localparam [2:0] S_WR   = 3'h3;
   localparam [2:0] S_RD   = 3'h4;
   localparam [2:0] S_RACK = 3'h5;
   localparam [2:0] S_WAIT = 3'h6;

   reg        shutdown_pin_meta;
   reg        shutdown_pin_sync;
   reg        rsel_meta;
   reg        rsel_sync;
   reg [2:0]  state;
   reg [3:0]  bit_cnt;
   reg [7:0]  shift;
   reg [7:0]  out_byte;
   reg [7:0]  sub_ptr;
   reg        is_read;
   reg        first_byte;
   reg        rd_sel;
   reg        drive_low;
   reg        wr_en;
   reg [2:0]  wr_addr;
   reg [7:0]  wr_data;
   reg [7:0]  cfg [0:`NUM_CFG_REGS-1];
   wire       run;
   wire       sda_level;
   wire       scl_rise;
   wire       scl_fall;
   wire       start_cond;
   wire       stop_cond;
   wire [7:0] status_first;
   wire [7:0] status_second;
   integer    i;

   // -------------------------------------------------------------------
   // Status byte select, first or second
   // -------------------------------------------------------------------
   function [7:0] status_byte;
      input       sel;
      input [7:0] first;
      input [7:0] second;
      begin
         status_byte = sel ? second : first;
      end
   endfunction

   function [7:0] cfg_reset;
      input [2:0] idx;
      begin
         case (idx)
            `SUB_FILTER_TRIM: cfg_reset = `RST_FILTER_TRIM;
            `SUB_CHARGE_PUMP: cfg_reset = `RST_CHARGE_PUMP;
            default:          cfg_reset = `RST_OTHER;
         endcase
      end
   endfunction

   // -------------------------------------------------------------------
   // Shutdown and reference-select pins
   // -------------------------------------------------------------------
   always @(posedge mclk_i) begin
      if (!nrst_i) begin
         shutdown_pin_meta <= 1'b0;
         shutdown_pin_sync <= 1'b0;
         rsel_meta <= 1'b1;
         rsel_sync <= 1'b1;
      end else begin
         shutdown_pin_meta <= shutdown_pin_n_i;
         shutdown_pin_sync <= shutdown_pin_meta;
         rsel_meta <= ref_source_select_i;
         rsel_sync <= rsel_meta;
      end
   end

   // Shutdown holds the serial slave and the configuration registers in reset; the pin synchronisers keep running
   assign run         = nrst_i & shutdown_pin_sync;
   assign device_on_o = run;

   serial_line_frontend u_frontend (
      .mclk_i      (mclk_i),
      .rst_i       (~run),
      .scl_i       (scl_i),
      .sda_i       (sda_i),
      .sda_level_o (sda_level),
      .scl_rise_o  (scl_rise),
      .scl_fall_o  (scl_fall),
      .start_o     (start_cond),
      .stop_o      (stop_cond)
   );

   // -------------------------------------------------------------------
   // Serial slave
   // -------------------------------------------------------------------
   assign status_first  = {3'h0, act_pump_current_i, power_indication_i,
                           autoselect_flag_a_i, autoselect_flag_e_i};
   assign status_second = {act_osc_select_i, act_sub_band_i,
                           converter_reading_i};

   always @(posedge mclk_i) begin
      wr_en <= 1'b0;
      if (!run) begin
         state      <= S_IDLE;
         bit_cnt    <= 4'h0;
         shift      <= 8'h00;
         out_byte   <= 8'h00;
         sub_ptr    <= 8'h00;
         is_read    <= 1'b0;
         first_byte <= 1'b0;
         rd_sel     <= 1'b0;
         drive_low  <= 1'b0;
         wr_addr    <= 3'h0;
         wr_data    <= 8'h00;
      end else if (start_cond) begin
         state     <= S_ADDR;
         bit_cnt   <= 4'h0;
         drive_low <= 1'b0;
      end else if (stop_cond) begin
         state     <= S_IDLE;
         drive_low <= 1'b0;
      end else begin
         case (state)
            S_ADDR: begin
               if (scl_rise) begin
                  shift   <= {shift[6:0], sda_level};
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (scl_fall && bit_cnt == `BITS_PER_BYTE) begin
                  if (shift[7:1] == DEV_ADDR) begin
                     drive_low  <= 1'b1;
                     is_read    <= shift[0];
                     first_byte <= 1'b1;
                     rd_sel     <= 1'b0;
                     state      <= S_ACK;
                  end else begin
                     state <= S_WAIT;
                  end
               end
            end
            S_ACK: begin
               if (scl_fall) begin
                  bit_cnt <= 4'h0;
                  if (is_read) begin
                     // Reads have no sub-address phase
                     out_byte  <= status_byte(rd_sel, status_first,
                                              status_second);
                     drive_low <= ~(rd_sel ? status_second[7]
                                           : status_first[7]);
                     rd_sel    <= ~rd_sel;
                     state     <= S_RD;
                  end else begin
                     drive_low <= 1'b0;
                     state     <= S_WR;
                  end
               end
            end
            S_WR: begin
               if (scl_rise) begin
                  shift   <= {shift[6:0], sda_level};
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (scl_fall && bit_cnt == `BITS_PER_BYTE) begin
                  if (first_byte) begin
                     sub_ptr    <= shift;
                     first_byte <= 1'b0;
                  end else begin
                     // Bytes past the last register are taken but dropped
                     wr_en   <= (sub_ptr[7:3] == 5'h00);
                     wr_addr <= sub_ptr[2:0];
                     wr_data <= shift;
                     sub_ptr <= sub_ptr + 8'h01;
                  end
                  drive_low <= 1'b1;
                  state     <= S_ACK;
               end
            end
            S_RD: begin
               if (scl_rise) begin
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (scl_fall) begin
                  if (bit_cnt == `BITS_PER_BYTE) begin
                     drive_low <= 1'b0;
                     state     <= S_RACK;
                  end else begin
                     drive_low <= ~out_byte[6];
                     out_byte  <= {out_byte[6:0], 1'b0};
                  end
               end
            end
            S_RACK: begin
               if (scl_rise) begin
                  shift[0] <= sda_level;
               end else if (scl_fall) begin
                  bit_cnt <= 4'h0;
                  if (!shift[0]) begin
                     out_byte  <= status_byte(rd_sel, status_first,
                                              status_second);
                     drive_low <= ~(rd_sel ? status_second[7]
                                           : status_first[7]);
                     rd_sel    <= ~rd_sel;
                     state     <= S_RD;
                  end else begin
                     state <= S_WAIT;
                  end
               end
            end
            S_IDLE, S_WAIT: begin
               drive_low <= 1'b0;
            end
            default: begin
               state     <= S_IDLE;
               drive_low <= 1'b0;
            end
         endcase
      end
   end

   // Open drain: only ever pulls low
   assign sda_o    = 1'b0;
   assign sda_oe_o = drive_low;

   // -------------------------------------------------------------------
   // Configuration registers
   // -------------------------------------------------------------------
   always @(posedge mclk_i) begin
      if (!run) begin
         for (i = 0; i < `NUM_CFG_REGS; i = i + 1) begin
            cfg[i] <= cfg_reset(i[2:0]);
         end
      end else if (wr_en) begin
         cfg[wr_addr] <= wr_data;
      end
   end

   assign filter_trim_code_o   = cfg[`SUB_FILTER_TRIM][`TRIM_CODE_MSB:`TRIM_CODE_LSB];
   assign trim_source_select_o = cfg[`SUB_FILTER_TRIM][`TRIM_SRC_BIT];
   assign mixer_disable_o      = cfg[`SUB_FILTER_TRIM][`MIXER_DIS_BIT];
   assign diag_select_o        = cfg[`SUB_FILTER_TRIM][`DIAG_MSB:`DIAG_LSB];

   assign pump_current_code_o     = cfg[`SUB_CHARGE_PUMP][`PUMP_CUR_MSB:`PUMP_CUR_LSB];
   assign pump_current_auto_o     = cfg[`SUB_CHARGE_PUMP][`PUMP_AUTO_BIT];
   assign prebias_enable_o        = cfg[`SUB_CHARGE_PUMP][`PREBIAS_EN_BIT];
   assign ref_prebias_time_o      = cfg[`SUB_CHARGE_PUMP][`REF_PREBIAS_BIT];
   assign fb_prebias_time_o       = cfg[`SUB_CHARGE_PUMP][`FB_PREBIAS_BIT];
   assign pump_on_time_o          = cfg[`SUB_CHARGE_PUMP][`PUMP_ON_BIT];
   assign osc_autoselect_enable_o = cfg[`SUB_CHARGE_PUMP][`AUTOSEL_EN_BIT];

   assign oscillator_select_o  = cfg[`SUB_OSC_BAND][`OSC_SEL_MSB:`OSC_SEL_LSB];
   assign sub_band_select_o    = cfg[`SUB_OSC_BAND][`SUB_BAND_MSB:`SUB_BAND_LSB];
   assign converter_latch_o    = cfg[`SUB_OSC_BAND][`CONV_LATCH_BIT];
   assign converter_enable_o   = cfg[`SUB_OSC_BAND][`CONV_EN_BIT];
   assign lock_time_constant_o = cfg[`SUB_OSC_BAND][`LOCK_TC_BIT];

   assign output_mode_o      = cfg[`SUB_OPERATING][`OUT_MODE_BIT];
   assign baseband_level_o   = cfg[`SUB_OPERATING][`BB_LEVEL_MSB:`BB_LEVEL_LSB];
   assign injection_side_o   = cfg[`SUB_OPERATING][`INJ_SIDE_BIT];
   assign detector_setting_o = cfg[`SUB_OPERATING][`DET_SET_MSB:`DET_SET_LSB];
   assign detector_enable_o  = cfg[`SUB_OPERATING][`DET_EN_BIT];

   assign ref_out_divide_o = cfg[`SUB_REF_DIV_POWER][`REF_OUT_DIV_MSB:`REF_OUT_DIV_LSB];
   // Shutdown forces power-down and standby on
   assign power_down_o     = ~run | cfg[`SUB_REF_DIV_POWER][`PWR_DOWN_BIT];
   assign standby_o        = ~run | cfg[`SUB_REF_DIV_POWER][`STANDBY_BIT];
   assign quadrature_off_o = cfg[`SUB_REF_DIV_POWER][`QUAD_OFF_BIT];

   assign ref_divider_ratio_o = cfg[`SUB_REF_DIVIDER];
   assign fb_divider_ratio_o  = {cfg[`SUB_FB_DIV_HIGH],
                                 cfg[`SUB_FB_DIV_LOW][`FB_LOW_MSB:`FB_LOW_LSB]};

   // -------------------------------------------------------------------
   // Reference source and test output
   // -------------------------------------------------------------------
   assign tcxo_enable_o = run & rsel_sync;
   assign xtal_enable_o = run & ~rsel_sync;

   always @(posedge mclk_i) begin
      if (!run) begin
         test_out_o <= 1'b0;
      end else begin
         case (diag_select_o)
            `DIAG_FB_DIV:  test_out_o <= fb_div_tap_i;
            `DIAG_REF_DIV: test_out_o <= ref_div_tap_i;
            `DIAG_LO:      test_out_o <= lo_tap_i;
            default:       test_out_o <= 1'b0;
         endcase
      end
   end

endmodule // tuner_control_register_bank

// ===== tuner_host_model.sv
// Host model: two-wire bus master that frames bytes on the link.
// Assumes the bench resolves the open-drain data wire from both pulls.
`timescale 1ns/10ps
module tuner_host_model (
   input  wire mclk_i,   // System clock
   input  wire sda_w_i,  // Resolved data wire
   output reg  scl_o,    // Link clock, idles high
   output reg  pull_o    // High pulls data low
);
   reg [8:0] rx;         // Byte and ack bit seen on the wire
   initial begin
      scl_o = 1'b1;
      pull_o = 1'b0;
      rx = 9'h000;
   end
   // Data moves only while the clock is low, MSB first
   task bits(input [8:0] tx);
      integer i;
      for (i = 8; i >= 0; i--) begin
         @(posedge mclk_i) pull_o <= ~tx[i];
         repeat (2) @(posedge mclk_i);
         scl_o <= 1'b1;
         repeat (4) @(posedge mclk_i);
         rx = {rx[7:0], sda_w_i};
         scl_o <= 1'b0;
         @(posedge mclk_i);
      end
   endtask
   task start;
      @(posedge mclk_i) pull_o <= 1'b1;
      repeat (4) @(posedge mclk_i);
      scl_o <= 1'b0;
      repeat (3) @(posedge mclk_i);
   endtask
   task stop;
      @(posedge mclk_i) pull_o <= 1'b1;
      repeat (2) @(posedge mclk_i);
      scl_o <= 1'b1;
      repeat (4) @(posedge mclk_i);
      pull_o <= 1'b0;
      repeat (4) @(posedge mclk_i);
   endtask
endmodule // tuner_host_model

// ===== tuner_ctrl_assertions.sv
// Checker of port timing for the tuner control register bank.
// Assumes it is bound to the bank's top module by port name.
`timescale 1ns/10ps
module tuner_ctrl_assertions (
   input wire        mclk_i, nrst_i, shutdown_pin_n_i, scl_i, ref_source_select_i,
   input wire        sda_oe_o, device_on_o, tcxo_enable_o, xtal_enable_o, test_out_o,
   input wire        power_down_o, standby_o, fb_div_tap_i, ref_div_tap_i, lo_tap_i,
   input wire [2:0]  diag_select_o,
   input wire [7:0]  ref_divider_ratio_o,
   input wire [12:0] fb_divider_ratio_o
);
   reg tap_exp;
   always @(posedge mclk_i) begin
      tap_exp <= device_on_o && (diag_select_o == 3'h5 ? fb_div_tap_i :
                 diag_select_o == 3'h6 ? ref_div_tap_i : diag_select_o == 3'h7 & lo_tap_i);
   end
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);
   sequence shutdown_pin_held; !shutdown_pin_n_i [*3]; endsequence
   sequence ref_held(v); (device_on_o && ref_source_select_i == v) [*4]; endsequence
   a_src_exclusive: assert property (!(tcxo_enable_o && xtal_enable_o))
      else $error("both reference inputs on");
   a_src_external: assert property (ref_held(1'b1) |-> tcxo_enable_o)
      else $error("external source off");
   a_src_crystal: assert property (ref_held(1'b0) |-> xtal_enable_o)
      else $error("crystal input off");
   a_shutdown_pin_offline: assert property (shutdown_pin_held |-> !device_on_o && power_down_o)
      else $error("device on in shutdown");
   a_off_lowpower: assert property (!device_on_o |-> power_down_o && standby_o)
      else $error("low power missing while off");
   a_test_route: assert property (test_out_o == tap_exp)
      else $error("test output routing wrong");
   a_ack_scl_low: assert property ($changed(sda_oe_o) |-> !$past(scl_i, 2))
      else $error("data drive moved with clock high");
   a_cfg_on_ack: assert property ($changed({ref_divider_ratio_o, fb_divider_ratio_o})
      && device_on_o |-> sda_oe_o) else $error("ratio changed outside ack");
endmodule // tuner_ctrl_assertions

// ===== tuner_control_register_bank_bench.sv
// Bench: drives the tuner register bank through the host model.
// Assumes the design files and the host model compile before it.
`timescale 1ns/10ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
   $display("mismatch at %0t: %h not %h", $time, a, e); end end
module tuner_control_register_bank_bench;
   reg mclk_i, nrst_i, shutdown_pin_n_i, ref_source_select_i, power_indication_i;
   reg fb_div_tap_i, ref_div_tap_i, lo_tap_i, autoselect_flag_a_i, autoselect_flag_e_i;
   reg [1:0] act_pump_current_i, act_osc_select_i;
   reg [2:0] act_sub_band_i, converter_reading_i;
   reg [7:0] cfg [0:7];
   integer n_mismatch = 0, tests_run = 0;
   wire scl_i, sda_i, sda_o, sda_oe_o, pull, device_on_o, tcxo_enable_o, xtal_enable_o;
   wire test_out_o, trim_source_select_o, mixer_disable_o, pump_current_auto_o;
   wire prebias_enable_o, ref_prebias_time_o, fb_prebias_time_o, pump_on_time_o;
   wire osc_autoselect_enable_o, converter_latch_o, converter_enable_o, standby_o;
   wire lock_time_constant_o, output_mode_o, injection_side_o, detector_enable_o;
   wire power_down_o, quadrature_off_o;
   wire [1:0] pump_current_code_o, oscillator_select_o, baseband_level_o;
   wire [2:0] filter_trim_code_o, diag_select_o, sub_band_select_o, detector_setting_o;
   wire [4:0] ref_out_divide_o;
   wire [7:0] ref_divider_ratio_o;
   wire [12:0] fb_divider_ratio_o;
   assign sda_i = ~(pull | sda_oe_o);
   tuner_control_register_bank tuner_control_register_bank_i (.*);
   tuner_host_model tuner_host_model_i (.mclk_i, .sda_w_i(sda_i), .scl_o(scl_i), .pull_o(pull));
   task wr(input [7:0] sub, input integer n);
      integer i;
      tuner_host_model_i.start;
      tuner_host_model_i.bits(9'h181);
      `CHK(tuner_host_model_i.rx[0], 1'b0)
      tuner_host_model_i.bits({sub, 1'b1});
      for (i = 0; i < n; i++) tuner_host_model_i.bits({cfg[sub + i], 1'b1});
      tuner_host_model_i.stop;
   endtask
   task t_write;
      integer i;
      for (i = 0; i < 8; i++) cfg[i] = {i[2:0], ~i[2:0], i[1:0]};
      wr(8'h00, 8);
      `CHK({filter_trim_code_o, trim_source_select_o, mixer_disable_o, diag_select_o}, cfg[0])
      `CHK({pump_current_code_o, pump_current_auto_o, prebias_enable_o, ref_prebias_time_o,
         fb_prebias_time_o, pump_on_time_o, osc_autoselect_enable_o}, cfg[1])
      `CHK({oscillator_select_o, sub_band_select_o, converter_latch_o, converter_enable_o,
         lock_time_constant_o}, cfg[2])
      `CHK({output_mode_o, baseband_level_o, injection_side_o, detector_setting_o,
         detector_enable_o}, cfg[3])
      `CHK({ref_out_divide_o, power_down_o, standby_o, quadrature_off_o}, cfg[4])
      `CHK(ref_divider_ratio_o, cfg[5])
      `CHK(fb_divider_ratio_o, {cfg[6], cfg[7][7:3]})
   endtask
   task t_read;
      {act_pump_current_i, power_indication_i, autoselect_flag_a_i, autoselect_flag_e_i} <= 5'h16;
      {act_osc_select_i, act_sub_band_i, converter_reading_i} <= 8'hA5;
      tuner_host_model_i.start;
      tuner_host_model_i.bits(9'h0C3);
      `CHK(tuner_host_model_i.rx[0], 1'b1)
      tuner_host_model_i.stop;
      tuner_host_model_i.start;
      tuner_host_model_i.bits(9'h183);
      `CHK(sda_o, 1'b0)
      tuner_host_model_i.bits(9'h1FE);
      `CHK(tuner_host_model_i.rx[8:1], 8'h16)
      tuner_host_model_i.bits(9'h1FE);
      `CHK(tuner_host_model_i.rx[8:1], 8'hA5)
      tuner_host_model_i.bits(9'h1FF);
      `CHK(tuner_host_model_i.rx[8:1], 8'h16)
      tuner_host_model_i.stop;
   endtask
   task t_diag;
      integer c;
      reg [2:0] t;
      for (c = 5; c < 9; c++) begin
         cfg[0] = {5'h02, c[2:0]};
         wr(8'h00, 1);
         t = (c < 8) ? 3'h4 >> (c - 5) : 3'h7;
         {fb_div_tap_i, ref_div_tap_i, lo_tap_i} <= t;
         repeat (2) @(posedge mclk_i);
         `CHK(test_out_o, c < 8)
         {fb_div_tap_i, ref_div_tap_i, lo_tap_i} <= ~t;
         repeat (2) @(posedge mclk_i);
         `CHK(test_out_o, 1'b0)
      end
   endtask
   task t_power;
      ref_source_select_i <= 1'b0;
      repeat (5) @(posedge mclk_i);
      `CHK({tcxo_enable_o, xtal_enable_o}, 2'b01)
      ref_source_select_i <= 1'b1;
      repeat (5) @(posedge mclk_i);
      `CHK({tcxo_enable_o, xtal_enable_o}, 2'b10)
      shutdown_pin_n_i <= 1'b0;
      repeat (5) @(posedge mclk_i);
      `CHK({device_on_o, power_down_o, standby_o, tcxo_enable_o}, 4'h6)
      shutdown_pin_n_i <= 1'b1;
      repeat (5) @(posedge mclk_i);
      `CHK({device_on_o, power_down_o, ref_divider_ratio_o}, 10'h200)
   endtask
   task end_of_test;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      mclk_i = 1'b0;
      forever #50 mclk_i = ~mclk_i;
   end
   initial begin
      {nrst_i, shutdown_pin_n_i, ref_source_select_i, fb_div_tap_i, ref_div_tap_i} = 5'h0E;
      {lo_tap_i, power_indication_i, autoselect_flag_a_i, autoselect_flag_e_i} = 4'h0;
      {act_pump_current_i, act_osc_select_i, act_sub_band_i, converter_reading_i} = 10'h000;
      repeat (12) @(posedge mclk_i);
      nrst_i <= 1'b1;
      repeat (1000) @(posedge mclk_i); // Power-up settling before any access
      t_write;
      t_read;
      t_diag;
      t_power;
      end_of_test;
   end
   initial begin
      #2000000;
      n_mismatch++;
      end_of_test;
   end
endmodule // tuner_control_register_bank_bench
bind tuner_control_register_bank tuner_ctrl_assertions tuner_ctrl_assertions_i (.*);
